//--- src_pkg.sv
// Constants, register map and state encoding for the standby/reset control
package src_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [3:0] SRC_OFF_PCTL = 4'h0;
  localparam logic [3:0] SRC_OFF_STAT = 4'h4;
  localparam logic [3:0] SRC_OFF_CAUSE = 4'h8;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] SRC_PCTL_RST = 8'h26;
  localparam logic [7:0] SRC_PORT0_RST = 8'hff;
  localparam logic [11:0] SRC_PC_RST = 12'h000;
  localparam logic [9:0] SRC_TIMER_RST = 10'h000;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int SRC_PCTL_S0_MODE = 0;
  localparam int SRC_PCTL_S1_MODE = 2;
  localparam int SRC_PCTL_S2_EN = 3;
  localparam int SRC_OP_SENSE = 3;
  localparam int SRC_TMR_EN_BIT = 9;
  localparam int SRC_ST_FLAG = 5;
  localparam int SRC_ST_TEND = 6;
  localparam int SRC_ST_T9 = 7;
  localparam int SRC_ST_TCNT = 16;
  localparam int SRC_CAUSE_SUPPLY = 0;
  localparam int SRC_CAUSE_HALT = 1;
  localparam int SRC_CAUSE_ROT = 2;
  localparam int SRC_CAUSE_STACK = 3;

  // ------------------------------------------------------------------
  // Halt operand codes (low three bits)
  // ------------------------------------------------------------------
  localparam logic [2:0] SRC_OP_STOP_ALL0 = 3'h0;
  localparam logic [2:0] SRC_OP_STOP_ALL3 = 3'h3;
  localparam logic [2:0] SRC_OP_STOP_ONE = 3'h6;
  localparam logic [2:0] SRC_OP_HALT = 3'h5;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int SRC_INSTR_CLKS = 64;
  localparam int SRC_EARLY_CLKS = 4;
  localparam logic [1:0] SRC_AXI_OKAY = 2'h0;
  localparam logic [1:0] SRC_AXI_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // Standby state machine
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    SRC_RUN = 5'h01,
    SRC_HALT = 5'h02,
    SRC_DRAIN = 5'h04,
    SRC_STOP = 5'h08,
    SRC_OSCW = 5'h10
  } src_state_e;

endpackage : src_pkg

//--- src_standby_reset.sv
// Standby mode sequencing, timer and internal reset generation
`timescale 1ns/1ps

module src_standby_reset #(
  parameter int OSC_WAIT_CLKS = 534,
  parameter int OSC_W = 10,
  parameter bit SHORT_VARIANT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic halt_strobe,
  input wire logic [3:0] halt_operand,
  input wire logic tst_strobe,
  input wire logic tst_met,
  input wire logic timer_load,
  input wire logic [9:0] timer_data,
  input wire logic rot_fault,
  input wire logic stack_fault,
  input wire logic [7:0] key_scan_high,
  input wire logic [3:0] key_input_pins,
  input wire logic sense_input_zero,
  input wire logic sense_input_one,
  input wire logic sense_input_two,
  input wire logic supply_low,
  output logic cpu_run,
  output logic osc_stopped,
  output logic system_reset_n,
  output logic status_flag,
  output logic timer_end,
  output logic carrier_transmit_output,
  output logic transmit_indicator_output_n,
  output logic [7:0] port_control_reg_four,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import src_pkg::*;

  localparam logic [5:0] PRE_LAST = 6'(SRC_INSTR_CLKS - 1);
  localparam logic [5:0] PRE_START = SHORT_VARIANT ? 6'(SRC_EARLY_CLKS) : 6'h00;
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_WAIT_CLKS - 1);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [7:0] pin_raw;
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] pin_q;

  assign pin_raw = {supply_low, sense_input_two, sense_input_one,
                    sense_input_zero, key_input_pins};

  // Three stages; reset state is all low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A change counts once stages two and three agree
  for (genvar i = 0; i < 8; i++) begin : g_filt
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        pin_q[i] <= 1'b0;
      end else if (sync2[i] == sync3[i]) begin
        pin_q[i] <= sync3[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // State and decode
  // ------------------------------------------------------------------
  src_state_e st;
  src_state_e next_st;
  logic flag;
  logic next_flag;
  logic [3:0] held_op;
  logic [OSC_W-1:0] osc_cnt;
  logic [8:0] tcnt;
  logic t9;
  logic [5:0] pre;
  logic [7:0] pctl;
  logic [3:0] cause;

  wire [2:0] op_code = halt_operand[2:0];
  wire op_stop = (op_code == SRC_OP_STOP_ALL0) ||
                 (op_code == SRC_OP_STOP_ALL3) ||
                 (op_code == SRC_OP_STOP_ONE);
  wire op_halt = (op_code == SRC_OP_HALT);
  // Scan preconditions per stop code
  wire precond = op_halt ||
                 ((op_code == SRC_OP_STOP_ONE) ? key_scan_high[0]
                                               : &key_scan_high);
  wire halt_go = halt_strobe && (st == SRC_RUN);
  wire halt_bad = halt_go && (!(op_stop || op_halt) || !precond);
  wire tmr_zero = (tcnt == 9'h000);
  // Enabled sense pins for stop release
  wire sense_any = (pin_q[4] && pctl[SRC_PCTL_S0_MODE]) ||
                   (pin_q[5] && pctl[SRC_PCTL_S1_MODE]) ||
                   (pin_q[6] && pctl[SRC_PCTL_S2_EN]);
  wire key_any = |pin_q[3:0];
  wire new_stop_rel = key_any || (halt_operand[SRC_OP_SENSE] && sense_any);
  wire held_stop_rel = key_any || (held_op[SRC_OP_SENSE] && sense_any);
  wire new_rel = op_halt ? tmr_zero : new_stop_rel;
  // Any reset cause, including the filtered supply detector
  wire sys_rst = pin_q[7] || halt_bad || rot_fault || stack_fault;
  wire osc_done = (osc_cnt == OSC_LAST);
  wire tick = (pre == PRE_LAST);

  // ------------------------------------------------------------------
  // Standby sequencing
  // ------------------------------------------------------------------
  // Next state and status flag
  always_comb begin
    next_st = st;
    next_flag = flag;
    if (tst_strobe && st == SRC_RUN) begin
      next_flag = tst_met;
    end
    case (st)
      SRC_RUN: begin
        if (halt_go && flag) begin
          next_flag = new_rel;
        end else if (halt_go && new_rel) begin
          next_flag = 1'b1;
        end else if (halt_go && op_halt) begin
          next_st = SRC_HALT;
        end else if (halt_go && op_stop) begin
          next_st = (tmr_zero && !t9) ? SRC_STOP : SRC_DRAIN;
        end
      end
      SRC_HALT: begin
        if (tmr_zero) begin
          next_st = SRC_RUN;
          next_flag = 1'b1;
        end
      end
      SRC_DRAIN: begin
        if (tmr_zero) begin
          next_st = SRC_STOP;
        end
      end
      SRC_STOP: begin
        if (held_stop_rel) begin
          next_st = SRC_OSCW;
        end
      end
      SRC_OSCW: begin
        if (osc_done) begin
          next_st = held_stop_rel ? SRC_RUN : SRC_STOP;
          next_flag = held_stop_rel ? 1'b1 : flag;
        end
      end
      default: begin
        next_st = SRC_RUN;
      end
    endcase
    if (sys_rst) begin
      next_st = SRC_RUN;
      next_flag = 1'b0;
    end
  end

  // State, flag and held operand registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= SRC_RUN;
      flag <= 1'b0;
      held_op <= 4'h0;
    end else begin
      st <= next_st;
      flag <= next_flag;
      if (halt_go) begin
        held_op <= halt_operand;
      end
    end
  end

  // Oscillation wait counter, length set by parameter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      osc_cnt <= '0;
    end else if (st == SRC_OSCW && !osc_done) begin
      osc_cnt <= osc_cnt + OSC_W'(1);
    end else begin
      osc_cnt <= '0;
    end
  end

  // ------------------------------------------------------------------
  // Timer: 9-bit down counter plus output enable
  // ------------------------------------------------------------------
  // Loads only while running; zeroed in stop and on reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tcnt <= SRC_TIMER_RST[8:0];
      t9 <= SRC_TIMER_RST[SRC_TMR_EN_BIT];
      pre <= 6'h00;
    end else if (sys_rst || st == SRC_STOP || st == SRC_OSCW) begin
      tcnt <= SRC_TIMER_RST[8:0];
      t9 <= SRC_TIMER_RST[SRC_TMR_EN_BIT];
      pre <= 6'h00;
    end else if (timer_load && st == SRC_RUN) begin
      tcnt <= timer_data[8:0];
      t9 <= timer_data[SRC_TMR_EN_BIT];
      pre <= PRE_START;
    end else begin
      pre <= tick ? 6'h00 : pre + 6'h01;
      if (tick && !tmr_zero) begin
        tcnt <= tcnt - 9'h001;
      end
      if (st == SRC_DRAIN && tmr_zero) begin
        t9 <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  // Core run enable, oscillator stop, reset and timer outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cpu_run <= 1'b0;
      osc_stopped <= 1'b0;
      system_reset_n <= 1'b0;
      status_flag <= 1'b0;
      timer_end <= 1'b1;
      carrier_transmit_output <= 1'b0;
      transmit_indicator_output_n <= 1'b1;
    end else begin
      cpu_run <= (next_st == SRC_RUN) && !sys_rst;
      osc_stopped <= (next_st == SRC_STOP);
      system_reset_n <= !sys_rst;
      status_flag <= next_flag;
      timer_end <= tmr_zero;
      carrier_transmit_output <= t9;
      transmit_indicator_output_n <= !t9;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_pctl = do_write && (aw_addr == SRC_OFF_PCTL);
  wire wr_cause = do_write && (aw_addr == SRC_OFF_CAUSE);
  wire wr_ok = (aw_addr == SRC_OFF_PCTL) || (aw_addr == SRC_OFF_STAT) ||
               (aw_addr == SRC_OFF_CAUSE);
  wire do_read = s_axi_arvalid && s_axi_arready;
  wire [31:0] stat_word = {6'h00, t9, tcnt, 8'h00, t9, tmr_zero, flag, st};
  wire rd_ok = (s_axi_araddr == SRC_OFF_PCTL) ||
               (s_axi_araddr == SRC_OFF_STAT) ||
               (s_axi_araddr == SRC_OFF_CAUSE);
  wire [31:0] rd_word = (s_axi_araddr == SRC_OFF_PCTL) ? {24'h0, pctl} :
                        (s_axi_araddr == SRC_OFF_STAT) ? stat_word :
                        (s_axi_araddr == SRC_OFF_CAUSE) ? {28'h0, cause} :
                        32'h0;
  wire [3:0] cause_set = {stack_fault, rot_fault, halt_bad, pin_q[7]};
  wire [3:0] cause_clr = wr_cause && w_strb[0] ? w_data[3:0] : 4'h0;

  // Address and data are taken independently, answered together
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SRC_AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[3:2], 2'b00};
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? SRC_AXI_OKAY : SRC_AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready while nothing of that kind is pending
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_awvalid ? 1'b1 :
                       !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_wvalid ? 1'b1 :
                      !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= SRC_AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !do_read;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? SRC_AXI_OKAY : SRC_AXI_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Port control four; internal reset restores its default
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pctl <= SRC_PCTL_RST;
    end else if (sys_rst) begin
      pctl <= SRC_PCTL_RST;
    end else if (wr_pctl && w_strb[0]) begin
      pctl <= w_data[7:0];
    end
  end

  // Sticky reset causes, write one to clear, a new event wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cause <= 4'h0;
      port_control_reg_four <= SRC_PCTL_RST;
    end else begin
      cause <= (cause & ~cause_clr) | cause_set;
      port_control_reg_four <= (sys_rst ? SRC_PCTL_RST : pctl);
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_wake;
    st == SRC_STOP && held_stop_rel && !sys_rst;
  endsequence
  sequence s_wait_done;
    st == SRC_OSCW && osc_done && !sys_rst;
  endsequence

  stop_osc_a: assert property (
    st == SRC_STOP |-> osc_stopped && !cpu_run)
    else $error("oscillator not stopped in stop mode");
  halt_keep_a: assert property (
    st == SRC_HALT |-> !osc_stopped && !cpu_run)
    else $error("halt mode state wrong");
  stop_tmr_a: assert property (
    st == SRC_STOP |-> tcnt == 9'h000 && !t9)
    else $error("timer not zero in stop mode");
  flag_block_a: assert property (
    halt_go && flag && !sys_rst |=> st == SRC_RUN && flag == $past(new_rel))
    else $error("entry with flag set");
  skip_entry_a: assert property (
    halt_go && !flag && new_rel && !sys_rst |=> st == SRC_RUN && flag)
    else $error("entry although release met");
  halt_rel_a: assert property (
    st == SRC_HALT && tmr_zero && !sys_rst |=> st == SRC_RUN ##1 cpu_run)
    else $error("halt release failed");
  bad_op_a: assert property (
    halt_bad |=> !system_reset_n && st == SRC_RUN && !flag)
    else $error("bad halt operand without reset");
  drain_gate_a: assert property (
    st == SRC_STOP && $past(st) == SRC_DRAIN |-> tmr_zero && !t9)
    else $error("stop entered with timer busy");
  wake_wait_a: assert property (
    s_wake |=> st == SRC_OSCW)
    else $error("no oscillation wait on release");
  wait_end_a: assert property (
    s_wait_done |=> (st == SRC_RUN) == $past(held_stop_rel))
    else $error("wrong state after oscillation wait");
  tmr_dec_a: assert property (
    tick && !tmr_zero && st == SRC_RUN && !timer_load && !sys_rst
    |=> tcnt == $past(tcnt) - 9'h001)
    else $error("timer decrement wrong");
  rst_cause_a: assert property (
    rot_fault || stack_fault |=> !system_reset_n ##1 cpu_run == 1'b0
    || system_reset_n)
    else $error("fault without system reset");

endmodule : src_standby_reset

//--- src_key_model.sv
// Key matrix and sense switch model for the standby control
`timescale 1ns/1ps
module src_key_model (
  input wire logic [7:0] key_scan_high,
  input wire logic [3:0] press,
  input wire logic [2:0] sense_on,
  output logic [3:0] key_input_pins,
  output logic sense_input_zero,
  output logic sense_input_one,
  output logic sense_input_two
);
  // Keys close onto scan line 0; open lines fall to the pull-down
  always_comb begin
    key_input_pins = press & {4{key_scan_high[0]}};
    sense_input_zero = sense_on[0];
    sense_input_one = sense_on[1];
    sense_input_two = sense_on[2];
  end
endmodule : src_key_model

//--- src_standby_reset_test.sv
// Self-checking bench for the standby and reset control
`timescale 1ns/1ps
module src_standby_reset_test;
  import src_pkg::*;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic halt_strobe = 1'h0;
  logic [3:0] halt_operand = 4'h0;
  logic tst_strobe = 1'h0;
  logic tst_met = 1'h0;
  logic timer_load = 1'h0;
  logic [9:0] timer_data = 10'h0;
  logic rot_fault = 1'h0;
  logic stack_fault = 1'h0;
  logic supply_low = 1'h0;
  logic [7:0] key_scan_high = 8'hff;
  logic [3:0] press = 4'h0;
  logic [2:0] sense_on = 3'h0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [3:0] key_input_pins;
  logic sense_input_zero, sense_input_one, sense_input_two;
  logic cpu_run, osc_stopped, system_reset_n, status_flag, timer_end;
  logic carrier_transmit_output, transmit_indicator_output_n;
  logic [7:0] port_control_reg_four;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [31:0] rd;
  logic [1:0] rs;
  int failures = 0;
  int checks = 0;
  int n;

  // Short oscillation wait keeps the stop tests brief
  src_standby_reset #(.OSC_WAIT_CLKS(8)) uut (
    .clk_sys, .reset_n, .halt_strobe, .halt_operand, .tst_strobe,
    .tst_met, .timer_load, .timer_data, .rot_fault, .stack_fault,
    .key_scan_high, .key_input_pins, .sense_input_zero,
    .sense_input_one, .sense_input_two, .supply_low, .cpu_run,
    .osc_stopped, .system_reset_n, .status_flag, .timer_end,
    .carrier_transmit_output, .transmit_indicator_output_n,
    .port_control_reg_four, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  src_key_model far (
    .key_scan_high, .press, .sense_on, .key_input_pins,
    .sense_input_zero, .sense_input_one, .sense_input_two
  );

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  task final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick

  // One-cycle strobe: 0 halt, 1 status test, 2 timer load
  task cmd(input int k, input logic [9:0] d);
    @(posedge clk_sys);
    halt_operand <= d[3:0];
    tst_met <= d[0];
    timer_data <= d;
    halt_strobe <= (k == 0);
    tst_strobe <= (k == 1);
    timer_load <= (k == 2);
    @(posedge clk_sys);
    {halt_strobe, tst_strobe, timer_load} <= 3'h0;
  endtask : cmd

  // Bounded wait on 0 cpu_run, 1 osc_stopped, 2 timer_end
  task wait_for(input int sel, input logic v, input int lim, output int k);
    logic s;
    for (k = 0; k < lim; k++) begin
      @(posedge clk_sys);
      #1;
      s = sel == 0 ? cpu_run : (sel == 1 ? osc_stopped : timer_end);
      if (s === v) break;
    end
    check("wait", v, s);
    if (s !== v) final_report();
  endtask : wait_for

  task axi_wr(input logic [3:0] a, input logic [31:0] d,
              output logic [1:0] r);
    int k;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    check("bvalid", 1'h1, s_axi_bvalid);
    if (s_axi_bvalid !== 1'h1) final_report();
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, output logic [31:0] d,
              output logic [1:0] r);
    int k;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    check("rvalid", 1'h1, s_axi_rvalid);
    if (s_axi_rvalid !== 1'h1) final_report();
  endtask : axi_rd

  // Values after power-up and refused addresses
  task t_reset();
    check("pctl_pin", SRC_PCTL_RST, port_control_reg_four);
    check("flag", 1'h0, status_flag);
    check("tend", 1'h1, timer_end);
    axi_rd(SRC_OFF_PCTL, rd, rs);
    check("pctl", SRC_PCTL_RST, rd);
    axi_rd(4'hc, rd, rs);
    check("rd_bad", SRC_AXI_SLVERR, rs);
    axi_wr(4'hc, 32'h1, rs);
    check("wr_bad", SRC_AXI_SLVERR, rs);
    // A write with byte lane zero disabled leaves the register alone
    s_axi_wstrb <= 4'h0;
    axi_wr(SRC_OFF_PCTL, 32'h0, rs);
    s_axi_wstrb <= 4'hf;
    check("wr_ok", SRC_AXI_OKAY, rs);
    axi_rd(SRC_OFF_PCTL, rd, rs);
    check("pctl_strb", SRC_PCTL_RST, rd);
  endtask : t_reset

  // Undefined code, unmet precondition, rotate, stack and supply faults
  task t_fault();
    int i;
    logic seen;
    int cb [5] = '{SRC_CAUSE_HALT, SRC_CAUSE_HALT, SRC_CAUSE_ROT,
                   SRC_CAUSE_STACK, SRC_CAUSE_SUPPLY};
    for (i = 0; i < 5; i++) begin
      axi_wr(SRC_OFF_PCTL, 32'h09, rs);
      cmd(1, {9'h0, i != 1});
      @(posedge clk_sys);
      key_scan_high <= (i == 1) ? 8'h00 : 8'hff;
      rot_fault <= (i == 2);
      stack_fault <= (i == 3);
      supply_low <= (i == 4);
      if (i < 2) cmd(0, {8'h0, i == 0, 1'h0});
      else @(posedge clk_sys);
      {rot_fault, stack_fault} <= 2'h0;
      seen = 1'h0;
      repeat (8) begin
        @(posedge clk_sys);
        if (system_reset_n === 1'h0) seen = 1'h1;
      end
      supply_low <= 1'h0;
      check("sysrst", 1'h1, seen);
      check("flag_rst", 1'h0, status_flag);
      check("pctl_rst", SRC_PCTL_RST, port_control_reg_four);
      axi_rd(SRC_OFF_CAUSE, rd, rs);
      check("cause", 32'h1 << cb[i], rd);
      axi_wr(SRC_OFF_CAUSE, 32'hf, rs);
    end
  endtask : t_fault

  // Drain, stop, a press released during the oscillation wait, then every stop code
  task t_stop();
    int i;
    logic [3:0] op [4] = '{4'h3, 4'h6, 4'h8, 4'he};
    axi_wr(SRC_OFF_PCTL, 32'h09, rs);
    tick(1);
    check("pctl_wr", 32'h09, port_control_reg_four);
    @(posedge clk_sys);
    key_scan_high <= 8'hff;
    cmd(2, 10'h202);
    cmd(1, 10'h0);
    cmd(0, 10'h0);
    tick(2);
    check("drain", 1'h0, osc_stopped);
    wait_for(1, 1'h1, 400, n);
    check("drain_len", 1'h1, n >= SRC_INSTR_CLKS);
    check("tmr_zero", 1'h1, timer_end);
    check("stop_run", 1'h0, cpu_run);
    @(posedge clk_sys);
    press <= 4'h1;
    sense_on <= 3'h1;
    repeat (6) @(posedge clk_sys);
    press <= 4'h0;
    tick(30);
    check("restop", 1'h1, osc_stopped);
    check("restop_run", 1'h0, cpu_run);
    @(posedge clk_sys);
    press <= 4'h2;
    wait_for(0, 1'h1, 60, n);
    check("key_flag", 1'h1, status_flag);
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      {press, sense_on} <= 7'h0;
      key_scan_high <= (i == 1) ? 8'h01 : 8'hff;
      tick(8); // idle cycles stand for the no-op after wake
      cmd(1, 10'h0);
      cmd(0, {6'h0, op[i]});
      tick(4);
      check("stopped", 1'h1, osc_stopped);
      @(posedge clk_sys);
      if (i < 2) press <= 4'h8;
      else sense_on <= (i == 2) ? 3'h1 : 3'h4;
      wait_for(0, 1'h1, 60, n);
      check("rel_flag", 1'h1, status_flag);
    end
    @(posedge clk_sys);
    {press, sense_on} <= 7'h0;
    tick(8);
  endtask : t_stop

  // Halt until timer zero, then flag-set and already-met cases
  task t_halt();
    cmd(2, 10'h203);
    cmd(1, 10'h0);
    cmd(0, 10'h00d);
    tick(2);
    check("halted", 1'h0, cpu_run);
    check("carrier", 1'h1, carrier_transmit_output);
    check("ind_n", 1'h0, transmit_indicator_output_n);
    wait_for(0, 1'h1, 600, n);
    check("halt_len", 1'h1, n >= 2 * SRC_INSTR_CLKS &&
          n <= 4 * SRC_INSTR_CLKS);
    check("flag_rel", 1'h1, status_flag);
    check("tend", 1'h1, timer_end);
    cmd(0, 10'h005);
    tick(2);
    check("no_entry", 1'h1, cpu_run);
    check("flag_kept", 1'h1, status_flag);
    cmd(2, 10'h005);
    cmd(0, 10'h005);
    tick(2);
    check("no_entry2", 1'h1, cpu_run);
    check("flag_clr", 1'h0, status_flag);
    wait_for(2, 1'h1, 600, n);
    cmd(0, 10'h005);
    tick(2);
    check("skip", 1'h1, cpu_run);
    check("flag_skip", 1'h1, status_flag);
  endtask : t_halt

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'h1;
    tick(3);
    t_reset();
    t_fault();
    t_stop();
    t_halt();
    final_report();
  end
endmodule : src_standby_reset_test
